// *** src/dsg_guard.sv ***
// Purpose: Data space partitioning, read filtering and software stack guard
// Assumes: Core presents raw memory words beside each read request
// Notes:   Stack error trap is combinational in the cycle of the offending address
`timescale 1ns/100ps
`default_nettype none
`include "dsg_consts.svh"

module dsg_guard (
	input  wire logic                   ref_clk_in,
	input  wire logic                   arst_n_in,
	input  wire logic [`DSG_AW-1:0]     reg_addr_in,
	input  wire logic [`DSG_DW-1:0]     reg_wdata_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	output logic      [`DSG_DW-1:0]     reg_rdata_out,
	input  wire logic                   dsp_class_in,
	input  wire logic                   x_rd_in,
	input  wire dsg_pkg::dsg_mode_e     x_mode_in,
	input  wire logic [`DSG_PTRW-1:0]   x_ptr_in,
	input  wire logic [`DSG_DW-1:0]     x_addr_in,
	input  wire logic [`DSG_DW-1:0]     x_raw_in,
	input  wire logic                   y_rd_in,
	input  wire logic [`DSG_PTRW-1:0]   y_ptr_in,
	input  wire logic [`DSG_DW-1:0]     y_addr_in,
	input  wire logic [`DSG_DW-1:0]     y_raw_in,
	output logic      [`DSG_DW-1:0]     x_ea_out,
	output logic      [`DSG_DW-1:0]     x_rd_data_out,
	output logic                        x_valid_out,
	output logic                        x_fault_out,
	output logic      [`DSG_DW-1:0]     y_rd_data_out,
	output logic                        y_valid_out,
	output logic                        y_fault_out,
	input  wire logic                   push_in,
	input  wire logic                   pop_in,
	input  wire dsg_pkg::dsg_push_kind_e push_kind_in,
	input  wire logic [`DSG_DW-1:0]     push_word_in,
	input  wire logic [7:0]             pc_msb_in,
	input  wire logic [7:0]             status_low_byte_in,
	input  wire logic                   sp_ea_in,
	input  wire logic [`DSG_DW-1:0]     sp_ea_addr_in,
	output logic      [`DSG_DW-1:0]     stk_ea_out,
	output logic      [`DSG_DW-1:0]     stk_data_out,
	output logic                        stk_valid_out,
	output logic                        stk_write_out,
	output logic      [`DSG_DW-1:0]     stack_pointer_reg_out,
	output logic                        stack_err_trap_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	dsg_pkg::dsg_state_s state_q;
	dsg_pkg::dsg_state_s state_d;
	logic [`DSG_DW-1:0]  stack_limit_reg_q;
	logic [`DSG_DW-1:0]  x_ea;
	logic                x_in_y;
	logic                x_impl;
	logic                x_ok;
	logic                y_in_y;
	logic                y_ok;
	logic                wr_sp;
	logic                wr_limit;
	logic [`DSG_DW-1:0]  stk_ea;
	logic [`DSG_DW-1:0]  stk_word;
	logic                stk_act;
	logic                over_err;
	logic                under_err;

	assign wr_sp    = reg_wr_in && (reg_addr_in == `DSG_OFS_SP);
	assign wr_limit = reg_wr_in && (reg_addr_in == `DSG_OFS_LIMIT);

	// ----------------------------------------
	// Stack limit register
	// ----------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (wr_limit) begin
			stack_limit_reg_q <= {reg_wdata_in[`DSG_DW-1:1], 1'b0};
		end
	end

	// ----------------------------------------
	// X address resolution
	// ----------------------------------------
	always_comb begin
		case (x_mode_in)
			dsg_pkg::DSG_MODE_NEAR: begin
				x_ea = {{(`DSG_DW-`DSG_NEAR_BITS){1'b0}}, x_addr_in[`DSG_NEAR_BITS-1:0]};
			end
			dsg_pkg::DSG_MODE_WIDE: begin
				x_ea = x_addr_in;
			end
			dsg_pkg::DSG_MODE_INDIRECT: begin
				x_ea = x_addr_in;
			end
			default: begin
				x_ea = x_addr_in;
			end
		endcase
	end

	assign x_in_y = (x_ea >= `DSG_Y_BASE) && (x_ea <= `DSG_Y_END);
	assign x_impl = (x_ea <= `DSG_IMPL_END) || (x_ea >= `DSG_PSV_BASE);
	assign y_in_y = (y_addr_in >= `DSG_Y_BASE) && (y_addr_in <= `DSG_Y_END);

	always_comb begin
		if (dsp_class_in) begin
			x_ok = x_impl && !x_in_y && (x_mode_in == dsg_pkg::DSG_MODE_INDIRECT) &&
			       ((x_ptr_in == `DSG_PTR_XA) || (x_ptr_in == `DSG_PTR_XB));
		end else begin
			x_ok = x_impl;
		end
	end

	assign y_ok = dsp_class_in && y_in_y &&
	              ((y_ptr_in == `DSG_PTR_YA) || (y_ptr_in == `DSG_PTR_YB));

	// ----------------------------------------
	// Stack addressing and checks
	// ----------------------------------------
	always_comb begin
		stk_act = push_in || pop_in || sp_ea_in;
		if (push_in) begin
			stk_ea = state_q.sp;
		end else if (pop_in) begin
			stk_ea = state_q.sp - `DSG_WORD_STEP;
		end else begin
			stk_ea = sp_ea_addr_in;
		end
		case (push_kind_in)
			dsg_pkg::DSG_PUSH_CALL: begin
				stk_word = {8'h00, pc_msb_in};
			end
			dsg_pkg::DSG_PUSH_EXC: begin
				stk_word = {status_low_byte_in, pc_msb_in};
			end
			default: begin
				stk_word = push_word_in;
			end
		endcase
	end

	assign over_err  = stk_act && (stk_ea > stack_limit_reg_q);
	assign under_err = stk_act && (stk_ea < `DSG_SFR_END);
	assign stack_err_trap_out = over_err || under_err;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.reg_rdata = '0;
		if (reg_rd_in) begin
			if (reg_addr_in == `DSG_OFS_SP) begin
				state_d.reg_rdata = state_q.sp;
			end else if (reg_addr_in == `DSG_OFS_LIMIT) begin
				state_d.reg_rdata = stack_limit_reg_q;
			end
		end
		state_d.x_valid = x_rd_in;
		state_d.x_fault = x_rd_in && !x_ok;
		state_d.x_ea    = x_rd_in ? x_ea : state_q.x_ea;
		state_d.x_data  = (x_rd_in && x_ok) ? x_raw_in : '0;
		state_d.y_valid = y_rd_in;
		state_d.y_fault = y_rd_in && !y_ok;
		state_d.y_data  = (y_rd_in && y_ok) ? y_raw_in : '0;
		state_d.stk_valid = push_in || pop_in;
		state_d.stk_write = push_in;
		if (push_in || pop_in) begin
			state_d.stk_ea   = stk_ea;
			state_d.stk_data = push_in ? stk_word : '0;
		end
		if (wr_sp) begin
			state_d.sp = {reg_wdata_in[`DSG_DW-1:1], 1'b0};
		end else if (push_in) begin
			state_d.sp = state_q.sp + `DSG_WORD_STEP;
		end else if (pop_in) begin
			state_d.sp = state_q.sp - `DSG_WORD_STEP;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q    <= '0;
			state_q.sp <= `DSG_SP_RST;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_out         = state_q.reg_rdata;
	assign x_ea_out              = state_q.x_ea;
	assign x_rd_data_out         = state_q.x_data;
	assign x_valid_out           = state_q.x_valid;
	assign x_fault_out           = state_q.x_fault;
	assign y_rd_data_out         = state_q.y_data;
	assign y_valid_out           = state_q.y_valid;
	assign y_fault_out           = state_q.y_fault;
	assign stk_ea_out            = state_q.stk_ea;
	assign stk_data_out          = state_q.stk_data;
	assign stk_valid_out         = state_q.stk_valid;
	assign stk_write_out         = state_q.stk_write;
	assign stack_pointer_reg_out = state_q.sp;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	push_step_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(push_in && !wr_sp) |=> (state_q.sp == $past(state_q.sp) + `DSG_WORD_STEP)
		&& (stk_ea_out == $past(state_q.sp)))
		else $error("push did not use and advance pointer");

	pop_step_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(pop_in && !push_in && !wr_sp) |=> (stk_ea_out == state_q.sp)
		&& (state_q.sp == $past(state_q.sp) - `DSG_WORD_STEP))
		else $error("pop did not pre-decrement pointer");

	call_msb_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(push_in && push_kind_in == dsg_pkg::DSG_PUSH_CALL)
		|=> (stk_data_out[15:8] == 8'h00) && (stk_data_out[7:0] == $past(pc_msb_in)))
		else $error("call push upper byte not clear");

	exc_word_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(push_in && push_kind_in == dsg_pkg::DSG_PUSH_EXC)
		|=> (stk_data_out == {$past(status_low_byte_in), $past(pc_msb_in)}))
		else $error("exception push word wrong");

	limit_align_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		wr_limit |=> (stack_limit_reg_q[0] == 1'b0) && (stack_limit_reg_q[15:1] == $past(reg_wdata_in[15:1])))
		else $error("stack limit not word aligned");

	at_limit_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(push_in && state_q.sp == stack_limit_reg_q && stack_limit_reg_q >= `DSG_SFR_END)
		|-> !stack_err_trap_out)
		else $error("push at limit trapped");

	past_limit_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(push_in && state_q.sp == stack_limit_reg_q + `DSG_WORD_STEP) |-> stack_err_trap_out)
		else $error("push beyond limit not trapped");

	underflow_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(sp_ea_in && !push_in && !pop_in && sp_ea_addr_in < `DSG_SFR_END) |-> stack_err_trap_out)
		else $error("underflow not trapped");

	near_zext_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(x_rd_in && x_mode_in == dsg_pkg::DSG_MODE_NEAR) |=> (x_ea_out <= `DSG_NEAR_END))
		else $error("near address beyond near region");

	dsp_x_zero_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(x_rd_in && dsp_class_in && x_in_y) |=> (x_rd_data_out == 16'h0000) && x_fault_out)
		else $error("dsp X read reached Y");

	y_ptr_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(y_rd_in && y_ptr_in != `DSG_PTR_YA && y_ptr_in != `DSG_PTR_YB)
		|=> y_fault_out && (y_rd_data_out == 16'h0000))
		else $error("Y read through wrong pointer");

	y_only_dsp_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(y_rd_in && !dsp_class_in) |=> y_fault_out)
		else $error("Y read outside dsp class");

	mcu_whole_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(x_rd_in && !dsp_class_in && x_in_y) |=> !x_fault_out && (x_rd_data_out == $past(x_raw_in)))
		else $error("non-dsp read blocked from Y");

	x_ptr_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(x_rd_in && dsp_class_in && x_ptr_in != `DSG_PTR_XA && x_ptr_in != `DSG_PTR_XB)
		|=> x_fault_out && (x_rd_data_out == 16'h0000))
		else $error("dsp X read through wrong pointer");

	unimpl_zero_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(x_rd_in && x_ea > `DSG_IMPL_END && x_ea < `DSG_PSV_BASE)
		|=> x_fault_out && (x_rd_data_out == 16'h0000))
		else $error("unimplemented read not zero");

	wide_ea_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(x_rd_in && x_mode_in == dsg_pkg::DSG_MODE_WIDE) |=> (x_ea_out == $past(x_addr_in)))
		else $error("wide move address altered");

	y_region_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(y_rd_in && (y_addr_in < `DSG_Y_BASE || y_addr_in > `DSG_Y_END))
		|=> y_fault_out && (y_rd_data_out == 16'h0000))
		else $error("Y read outside Y region not zero");

	sp_read_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(reg_rd_in && reg_addr_in == `DSG_OFS_SP)
		|=> (reg_rdata_out == $past(stack_pointer_reg_out)))
		else $error("stack pointer read wrong");

	limit_check_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(sp_ea_in && !push_in && !pop_in && sp_ea_addr_in > stack_limit_reg_q)
		|-> stack_err_trap_out)
		else $error("pointer address above limit not trapped");

	pop_read_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(pop_in && !push_in)
		|=> stk_valid_out && !stk_write_out && (stk_data_out == 16'h0000))
		else $error("pop shown as write");

	push_under_a: assert property (
		@(posedge ref_clk_in) disable iff (!arst_n_in)
		(push_in && state_q.sp < `DSG_SFR_END) |-> stack_err_trap_out)
		else $error("push below stack floor not trapped");

endmodule : dsg_guard
`default_nettype wire

// *** src/dsg_consts.svh ***
// Purpose: Constants for the data space map and stack guard
// Assumes: 16-bit byte addresses, word-aligned stack
// Notes:   Offsets are the printed register offsets
`ifndef DSG_CONSTS_SVH
`define DSG_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define DSG_DW             16
`define DSG_AW             8
`define DSG_PTRW           4

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define DSG_OFS_SP         8'h1E
`define DSG_OFS_LIMIT      8'h20
`define DSG_SP_RST         16'h0800

// ----------------------------------------
// Address map
// ----------------------------------------
`define DSG_NEAR_END       16'h1FFF
`define DSG_NEAR_BITS      13
`define DSG_SFR_END        16'h0800
`define DSG_Y_BASE         16'h1800
`define DSG_Y_END          16'h27FF
`define DSG_IMPL_END       16'h27FF
`define DSG_PSV_BASE       16'h8000
`define DSG_WORD_STEP      16'h0002

// ----------------------------------------
// Pointer register numbers
// ----------------------------------------
`define DSG_PTR_XA         4'h8
`define DSG_PTR_XB         4'h9
`define DSG_PTR_YA         4'hA
`define DSG_PTR_YB         4'hB
`define DSG_PTR_SP         4'hF

`endif

// *** src/dsg_pkg.sv ***
// Purpose: Types for the data space map and stack guard
// Assumes: dsg_consts.svh supplies widths
// Notes:   Holds types only
`include "dsg_consts.svh"

package dsg_pkg;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {
		DSG_PUSH_DATA,
		DSG_PUSH_CALL,
		DSG_PUSH_EXC
	} dsg_push_kind_e;

	typedef enum logic [1:0] {
		DSG_MODE_INDIRECT,
		DSG_MODE_NEAR,
		DSG_MODE_WIDE
	} dsg_mode_e;

	// ----------------------------------------
	// Module state
	// ----------------------------------------
	typedef struct packed {
		logic [`DSG_DW-1:0] sp;
		logic [`DSG_DW-1:0] reg_rdata;
		logic [`DSG_DW-1:0] x_data;
		logic [`DSG_DW-1:0] y_data;
		logic [`DSG_DW-1:0] x_ea;
		logic [`DSG_DW-1:0] stk_ea;
		logic [`DSG_DW-1:0] stk_data;
		logic               x_valid;
		logic               x_fault;
		logic               y_valid;
		logic               y_fault;
		logic               stk_valid;
		logic               stk_write;
	} dsg_state_s;

endpackage : dsg_pkg

// *** test/dsg_core_mem.sv ***
// Purpose: Memory side model returning raw words for X and Y reads
// Assumes: Raw word is a fixed pattern of the requested address
// Notes:   Pattern never equals the address, so a misrouted fetch shows
`timescale 1ns/100ps
`default_nettype none

module dsg_core_mem (
	input  wire logic [15:0] x_addr_in,
	input  wire logic [15:0] y_addr_in,
	output logic      [15:0] x_raw_out,
	output logic      [15:0] y_raw_out
);
	// ----------------------------------------
	// Raw fetch
	// ----------------------------------------
	assign x_raw_out = ~x_addr_in;
	assign y_raw_out = ~y_addr_in;
endmodule : dsg_core_mem
`default_nettype wire

// *** test/tb.sv ***
// Purpose: Self-checking bench for the data space map and stack guard
// Assumes: Expected results queued by the drivers
// Notes:   Outputs sampled at the falling edge
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic                    ref_clk_in = 1'b0, arst_n_in = 1'b0;
	logic [7:0]              reg_addr_in = 8'h00;
	logic [15:0]             reg_wdata_in = 16'h0000, reg_rdata_out;
	logic                    reg_wr_in = 1'b0, reg_rd_in = 1'b0, dsp_class_in = 1'b0;
	logic                    x_rd_in = 1'b0, y_rd_in = 1'b0;
	dsg_pkg::dsg_mode_e      x_mode_in = dsg_pkg::DSG_MODE_INDIRECT;
	logic [3:0]              x_ptr_in = 4'h0, y_ptr_in = 4'h0;
	logic [15:0]             x_addr_in = 16'h0000, y_addr_in = 16'h0000;
	logic [15:0]             x_raw_in, y_raw_in, x_ea_out, x_rd_data_out, y_rd_data_out;
	logic                    x_valid_out, x_fault_out, y_valid_out, y_fault_out;
	logic                    push_in = 1'b0, pop_in = 1'b0, sp_ea_in = 1'b0;
	dsg_pkg::dsg_push_kind_e push_kind_in = dsg_pkg::DSG_PUSH_DATA;
	logic [15:0]             push_word_in = 16'h0000, sp_ea_addr_in = 16'h0000;
	logic [7:0]              pc_msb_in = 8'h00, status_low_byte_in = 8'h00;
	logic [15:0]             stk_ea_out, stk_data_out, stack_pointer_reg_out;
	logic                    stk_valid_out, stk_write_out, stack_err_trap_out;
	logic [35:0]             rq[$], xq[$], yq[$], sq[$], tq[$], e;
	logic                    rd_s = 1'b0, xr_s = 1'b0, yr_s = 1'b0, pp_s = 1'b0;
	logic [15:0]             sp = 16'h0800, lim = 16'h0000, a;
	int                      mismatches = 0, n_checks = 0;

	dsg_guard u_dsg_guard (.ref_clk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .dsp_class_in, .x_rd_in, .x_mode_in, .x_ptr_in, .x_addr_in,
		.x_raw_in, .y_rd_in, .y_ptr_in, .y_addr_in, .y_raw_in, .x_ea_out, .x_rd_data_out,
		.x_valid_out, .x_fault_out, .y_rd_data_out, .y_valid_out, .y_fault_out, .push_in,
		.pop_in, .push_kind_in, .push_word_in, .pc_msb_in, .status_low_byte_in, .sp_ea_in,
		.sp_ea_addr_in, .stk_ea_out, .stk_data_out, .stk_valid_out, .stk_write_out,
		.stack_pointer_reg_out, .stack_err_trap_out);
	dsg_core_mem u_dsg_core_mem (.x_addr_in(x_addr_in), .y_addr_in(y_addr_in),
		.x_raw_out(x_raw_in), .y_raw_out(y_raw_in));

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	always #5 ref_clk_in = ~ref_clk_in;

	always @(posedge ref_clk_in) begin
		rd_s <= reg_rd_in;
		xr_s <= x_rd_in;
		yr_s <= y_rd_in;
		pp_s <= push_in | pop_in;
	end

	always @(negedge ref_clk_in) if (arst_n_in) begin
		chk("sp_out", stack_pointer_reg_out, sp);
		if (rd_s) chk("rdata", reg_rdata_out, rq.pop_front());
		else chk("rdata_idle", reg_rdata_out, 36'h0);
		if (xr_s) chk("x_rd", {x_valid_out, x_fault_out, x_ea_out, x_rd_data_out}, xq.pop_front());
		else chk("x_idle", {x_valid_out, x_fault_out, x_rd_data_out}, 36'h0);
		if (yr_s) chk("y_rd", {y_valid_out, y_fault_out, y_rd_data_out}, yq.pop_front());
		else chk("y_idle", {y_valid_out, y_fault_out, y_rd_data_out}, 36'h0);
		if (pp_s) begin
			e = sq.pop_front();
			chk("stk", {stk_valid_out, stk_write_out, stk_ea_out, e[32] ? stk_data_out : 16'h0000}, {1'b1, e[32:0]});
		end else begin
			chk("stk_idle", {stk_valid_out, stk_write_out}, 36'h0);
		end
		if (push_in | pop_in | sp_ea_in) chk("trap", stack_err_trap_out, tq.pop_front());
		else chk("trap_idle", stack_err_trap_out, 36'h0);
	end

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic bus(input logic w, input logic [7:0] ad, input logic [15:0] d);
		if (!w) rq.push_back(d);
		@(posedge ref_clk_in);
		reg_addr_in <= ad;
		reg_wdata_in <= d;
		reg_wr_in <= w;
		reg_rd_in <= !w;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		if (w && ad == 8'h1E) sp = d & 16'hFFFE;
		if (w && ad == 8'h20) lim = d & 16'hFFFE;
	endtask : bus

	task automatic stk(input int op, input logic [1:0] pk, input logic [15:0] ad);
		logic [15:0] ea, w, d;
		logic [7:0]  pc, st;
		w = 16'($urandom);
		pc = 8'($urandom);
		st = 8'($urandom);
		ea = (op == 1) ? sp - 16'h0002 : ((op == 2) ? ad : sp);
		d = (pk == 2'd1) ? {8'h00, pc} : ((pk == 2'd2) ? {st, pc} : w);
		tq.push_back({35'h0, (ea > lim) || (ea < 16'h0800)});
		if (op != 2) sq.push_back({3'h0, op == 0, ea, (op == 0) ? d : 16'h0000});
		@(posedge ref_clk_in);
		push_in <= (op == 0);
		pop_in <= (op == 1);
		sp_ea_in <= (op == 2);
		push_kind_in <= dsg_pkg::dsg_push_kind_e'(pk);
		push_word_in <= w;
		pc_msb_in <= pc;
		status_low_byte_in <= st;
		sp_ea_addr_in <= ad;
		@(posedge ref_clk_in);
		push_in <= 1'b0;
		pop_in <= 1'b0;
		sp_ea_in <= 1'b0;
		if (op == 0) sp = sp + 16'h0002;
		if (op == 1) sp = sp - 16'h0002;
	endtask : stk

	task automatic acc(input logic d, xe, input logic [1:0] m, input logic [3:0] xp,
		input logic [15:0] xa, xea, input logic xf, ye, input logic [3:0] yp,
		input logic [15:0] ya, input logic yf);
		if (xe) xq.push_back({2'b00, 1'b1, xf, xea, xf ? 16'h0000 : ~xa});
		if (ye) yq.push_back({18'h0, 1'b1, yf, yf ? 16'h0000 : ~ya});
		@(posedge ref_clk_in);
		dsp_class_in <= d;
		x_rd_in <= xe;
		x_mode_in <= dsg_pkg::dsg_mode_e'(m);
		x_ptr_in <= xp;
		x_addr_in <= xa;
		y_rd_in <= ye;
		y_ptr_in <= yp;
		y_addr_in <= ya;
		@(posedge ref_clk_in);
		x_rd_in <= 1'b0;
		y_rd_in <= 1'b0;
	endtask : acc

	initial begin
		repeat (20000) @(posedge ref_clk_in);
		mismatches++;
		report_and_stop();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(32'hD8B70E94));
		repeat (10) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		bus(0, 8'h1E, 16'h0800);
		bus(1, 8'h22, 16'hFFFF);
		bus(0, 8'h22, 16'h0000);
		bus(1, 8'h20, 16'h1003);
		bus(0, 8'h20, 16'h1002);
		bus(1, 8'h1E, 16'h1001);
		stk(0, 2'd0, 16'h0000);
		stk(0, 2'd1, 16'h0000);
		stk(0, 2'd2, 16'h0000);
		bus(0, 8'h1E, 16'h1006);
		stk(1, 2'd0, 16'h0000);
		stk(1, 2'd0, 16'h0000);
		stk(2, 2'd0, 16'h1004);
		stk(2, 2'd0, 16'h0FFE);
		stk(2, 2'd0, 16'h07FE);
		bus(1, 8'h1E, 16'h0802);
		stk(1, 2'd0, 16'h0000);
		stk(1, 2'd0, 16'h0000);
		stk(0, 2'd1, 16'h0000);
		acc(0, 1, 2'd0, 4'h1, 16'h1800, 16'h1800, 0, 0, 4'h0, 16'h0000, 0);
		acc(0, 1, 2'd0, 4'h1, 16'h2800, 16'h2800, 1, 0, 4'h0, 16'h0000, 0);
		acc(0, 1, 2'd0, 4'h2, 16'h8000, 16'h8000, 0, 0, 4'h0, 16'h0000, 0);
		acc(1, 1, 2'd0, 4'h8, 16'h1800, 16'h1800, 1, 0, 4'h0, 16'h0000, 0);
		acc(1, 1, 2'd0, 4'h9, 16'h0900, 16'h0900, 0, 1, 4'hA, 16'h1900, 0);
		acc(1, 1, 2'd0, 4'hA, 16'h0900, 16'h0900, 1, 1, 4'hB, 16'h27FE, 0);
		acc(1, 1, 2'd1, 4'h8, 16'h0900, 16'h0900, 1, 1, 4'h8, 16'h1900, 1);
		acc(1, 0, 2'd0, 4'h8, 16'h0000, 16'h0000, 0, 1, 4'hA, 16'h0900, 1);
		acc(0, 0, 2'd0, 4'h8, 16'h0000, 16'h0000, 0, 1, 4'hA, 16'h1900, 1);
		for (int i = 0; i < 6; i++) begin
			a = 16'($urandom);
			acc(0, 1, 2'd1, 4'h0, a, {3'b000, a[12:0]}, 0, 0, 4'h0, 16'h0000, 0);
			a = 16'($urandom_range(16'h27FF, 16'h2000));
			acc(0, 1, 2'd2, 4'h0, a, a, 0, 0, 4'h0, 16'h0000, 0);
		end
		repeat (2) @(posedge ref_clk_in);
		arst_n_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
		sp = 16'h0800;
		arst_n_in <= 1'b1;
		bus(0, 8'h20, 16'h1002);
		bus(0, 8'h1E, 16'h0800);
		stk(0, 2'd0, 16'h0000);
		repeat (3) @(posedge ref_clk_in);
		chk("left", rq.size() + xq.size() + yq.size() + sq.size() + tq.size(), 36'h0);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
